//--- common/prr_regs.svh
// Register indices, field positions, masks and signal positions of the pin router.
// Assumes nothing; holds definitions only.
`ifndef PRR_REGS_SVH
`define PRR_REGS_SVH

// Register indices; byte address is four times the index
`define PRR_IDX_LOGIC_EVENT 2'h0
`define PRR_IDX_COMM 2'h1
`define PRR_IDX_TIMER_A 2'h2
`define PRR_IDX_TIMER_B 2'h3
`define PRR_NREG 4
`define PRR_REG_W 8
`define PRR_RESET_VAL 8'h00

// Writable bits of each register
`define PRR_MASK_LOGIC_EVENT 8'h37
`define PRR_MASK_COMM 8'h15
`define PRR_MASK_TIMER_A 8'h3f
`define PRR_MASK_TIMER_B 8'h01

// Field positions
`define PRR_BIT_TABLE1 5
`define PRR_BIT_TABLE0 4
`define PRR_BIT_EVENT2 2
`define PRR_BIT_EVENT1 1
`define PRR_BIT_EVENT0 0
`define PRR_BIT_TWI 4
`define PRR_BIT_SPI 2
`define PRR_BIT_UART 0
`define PRR_BIT_TCB 0
`define PRR_TCA_SPLIT_FIRST 3

// Positions in the routed signal vector
`define PRR_POS_TWI 0
`define PRR_POS_SPI 2
`define PRR_POS_UART 6
`define PRR_POS_LUT 8
`define PRR_POS_TCA 10
`define PRR_POS_TCB 16
`define PRR_NSIG 17
`define PRR_NCOMM 8
`define PRR_NEVENT 3

`endif

//--- common/prr_pkg.sv
// Types shared by the pin router files.
// Assumes prr_regs.svh on the include path.
`include "prr_regs.svh"
package prr_pkg;
  typedef logic [`PRR_REG_W-1:0] prr_byte_t;
  typedef logic [`PRR_NSIG-1:0] prr_sig_t;
  typedef enum logic [1:0] {
    PRR_REG_LOGIC_EVENT,
    PRR_REG_COMM,
    PRR_REG_TIMER_A,
    PRR_REG_TIMER_B
  } prr_reg_e;
endpackage

//--- src/prr_reg_store.sv
// Small register store of the pin router with a registered read port.
// Assumes writes arrive already masked and one access at a time.
`timescale 1ns/1ps
`include "prr_regs.svh"
module prr_reg_store #(
  parameter int NREG = `PRR_NREG,
  parameter int WIDTH = `PRR_REG_W,
  parameter int IDX_W = 2
) (
  input wire logic clock,                     // System clock
  input wire logic srst,                      // Synchronous reset
  input wire logic wr_en,                     // Write strobe
  input wire logic [IDX_W-1:0] wr_idx,        // Write index
  input wire logic [WIDTH-1:0] wr_data,       // Masked write data
  input wire logic rd_en,                     // Read strobe
  input wire logic rd_hit,                    // Read index is mapped
  input wire logic [IDX_W-1:0] rd_idx,        // Read index
  output logic [WIDTH-1:0] rd_data,           // Registered read data
  output logic [NREG*WIDTH-1:0] regs_flat     // All registers
);
  logic [WIDTH-1:0] mem_reg [NREG];
  logic [WIDTH-1:0] mem_next [NREG];
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;

  if (NREG < 1 || NREG > 2**IDX_W || WIDTH < 1) begin : g_bad
    $error("prr_reg_store: bad NREG, WIDTH or IDX_W");
  end

  always_comb begin
    for (int k = 0; k < NREG; k++) begin
      mem_next[k] = mem_reg[k];
      if (wr_en && wr_idx == IDX_W'(k)) begin
        mem_next[k] = wr_data;
      end
    end
    rd_data_next = rd_data_reg;
    if (rd_en) begin
      rd_data_next = rd_hit ? mem_reg[rd_idx] : '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int k = 0; k < NREG; k++) begin
        mem_reg[k] <= WIDTH'(`PRR_RESET_VAL);
      end
      rd_data_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      rd_data_reg <= rd_data_next;
    end
  end

  for (genvar k = 0; k < NREG; k++) begin : g_flat
    assign regs_flat[k*WIDTH +: WIDTH] = mem_reg[k];
  end
  assign rd_data = rd_data_reg;
endmodule

//--- src/prr_pin_route_unit.sv
// Pin router: chooses default or alternative pins for peripheral signals
// and gates event outputs onto their pins, programmed over APB.
// Assumes pad inputs are asynchronous; peripheral signals share clock.
//
// Overview of operation
// - Each function is either gated onto a pin or moved default/alternative.
// - Lookup table 1 output goes to its alternative pin when bit 5 set.
// - Lookup table 0 output goes to its alternative pin when bit 4 set.
// - Bit 2 of first register enables event output 2 onto its pin.
// - Bit 1 of first register enables event output 1 onto its pin.
// - Bit 0 of first register enables event output 0 onto its pin.
// - Two-wire signals use alternative pins when second register bit 4 set.
// - Serial peripheral signals use alternative pins when bit 2 set.
// - Serial port signals use alternative pins when bit 0 set.
// - Timer A wave 5 moves only in split mode with bit 5.
// - Timer A wave 4 moves only in split mode with bit 4.
// - Timer A wave 3 moves only in split mode with bit 3.
// - Bit 2 moves timer A wave 2, low-byte channel 2 in split.
// - Bit 1 moves timer A wave 1, low-byte channel 1 in split.
// - Bit 0 moves timer A wave 0, low-byte channel 0 in split.
// - Timer B output goes to its alternative pin when fourth register bit 0 set.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "prr_regs.svh"
module prr_pin_route_unit #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,                     // System clock, 50 MHz
  input wire logic srst,                      // Synchronous reset, high
  input wire logic psel,                      // APB select
  input wire logic penable,                   // APB enable
  input wire logic pwrite,                    // APB direction
  input wire logic [ADDR_W-1:0] paddr,        // APB byte address
  input wire logic [31:0] pwdata,             // APB write data
  input wire logic [3:0] pstrb,               // APB byte strobes
  output logic [31:0] prdata,                 // APB read data
  output logic pready,                        // APB ready
  output logic pslverr,                       // APB error
  input wire logic [1:0] lut_out,             // Lookup table outputs
  input wire logic [2:0] event_ch,            // Event channel outputs
  input wire logic [1:0] twi_out,             // Two-wire drive values
  input wire logic [1:0] twi_oe,              // Two-wire drive enables
  output logic [1:0] twi_in,                  // Two-wire pin levels
  input wire logic [3:0] spi_out,             // Serial peripheral drive values
  input wire logic [3:0] spi_oe,              // Serial peripheral enables
  output logic [3:0] spi_in,                  // Serial peripheral pin levels
  input wire logic [1:0] uart_out,            // Serial port drive values
  input wire logic [1:0] uart_oe,             // Serial port enables
  output logic [1:0] uart_in,                 // Serial port pin levels
  input wire logic [5:0] tca_wave,            // Timer A waveform outputs
  input wire logic tca_split,                 // Timer A in split mode
  input wire logic tcb_out,                   // Timer B output
  output logic [`PRR_NSIG-1:0] def_pin_out,   // Default pin values
  output logic [`PRR_NSIG-1:0] def_pin_oe,    // Default pin enables
  input wire logic [`PRR_NCOMM-1:0] def_pin_in, // Default pin levels
  output logic [`PRR_NSIG-1:0] alt_pin_out,   // Alternative pin values
  output logic [`PRR_NSIG-1:0] alt_pin_oe,    // Alternative pin enables
  input wire logic [`PRR_NCOMM-1:0] alt_pin_in, // Alternative pin levels
  output logic [`PRR_NEVENT-1:0] event_pin_out, // Event pin values
  output logic [`PRR_NEVENT-1:0] event_pin_oe   // Event pin enables
);
  if (ADDR_W < 5) begin : g_bad
    $error("prr_pin_route_unit: ADDR_W must be at least 5");
  end

  logic [31:0] regs_flat;
  prr_pkg::prr_byte_t logic_event_route;
  prr_pkg::prr_byte_t comm_pin_route;
  prr_pkg::prr_byte_t timer_a_wave_route;
  prr_pkg::prr_byte_t timer_b_out_route;
  prr_pkg::prr_byte_t rd_data;

  logic mapped;
  logic [1:0] idx;
  logic wr_en;
  logic rd_en;
  prr_pkg::prr_byte_t wr_data;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  prr_pkg::prr_sig_t sel;
  prr_pkg::prr_sig_t src_out;
  prr_pkg::prr_sig_t src_oe;
  logic logic_table0_alt;
  logic logic_table1_alt;
  logic two_wire_alt;
  logic serial_periph_alt;
  logic serial_port_alt;
  logic timer_a_wave0_alt;
  logic timer_a_wave1_alt;
  logic timer_a_wave2_alt;
  logic timer_a_wave3_alt;
  logic timer_a_wave4_alt;
  logic timer_a_wave5_alt;
  logic timer_b_out_alt;
  logic event_pin0_enable;
  logic event_pin1_enable;
  logic event_pin2_enable;

  prr_pkg::prr_sig_t def_out_reg, def_out_next;
  prr_pkg::prr_sig_t def_oe_reg, def_oe_next;
  prr_pkg::prr_sig_t alt_out_reg, alt_out_next;
  prr_pkg::prr_sig_t alt_oe_reg, alt_oe_next;
  logic [`PRR_NCOMM-1:0] def_sync1_reg, def_sync2_reg;
  logic [`PRR_NCOMM-1:0] alt_sync1_reg, alt_sync2_reg;
  logic [`PRR_NCOMM-1:0] comm_in_reg, comm_in_next;
  logic [`PRR_NEVENT-1:0] ev_out_reg, ev_out_next;
  logic [`PRR_NEVENT-1:0] ev_oe_reg, ev_oe_next;
  logic [`PRR_NEVENT-1:0] ev_en;

  // Writable bits of a register
  function automatic prr_pkg::prr_byte_t reg_mask(input logic [1:0] i);
    case (prr_pkg::prr_reg_e'(i))
      prr_pkg::PRR_REG_LOGIC_EVENT: reg_mask = `PRR_MASK_LOGIC_EVENT;
      prr_pkg::PRR_REG_COMM: reg_mask = `PRR_MASK_COMM;
      prr_pkg::PRR_REG_TIMER_A: reg_mask = `PRR_MASK_TIMER_A;
      default: reg_mask = `PRR_MASK_TIMER_B;
    endcase
  endfunction

  // APB slave: ready one cycle after setup, write at the ready edge
  always_comb begin
    idx = paddr[3:2];
    mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:4] == '0);
    wr_en = psel && penable && pready_reg && pwrite && mapped && pstrb[0];
    wr_data = pwdata[7:0] & reg_mask(idx);
    rd_en = psel && !penable && !pwrite;
    pready_next = psel && !penable;
    pslverr_next = pslverr_reg;
    if (psel && !penable) begin
      pslverr_next = !mapped;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  prr_reg_store #(
    .NREG(`PRR_NREG),
    .WIDTH(`PRR_REG_W),
    .IDX_W(2)
  ) u_store (
    .clock(clock),
    .srst(srst),
    .wr_en(wr_en),
    .wr_idx(idx),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_hit(mapped),
    .rd_idx(idx),
    .rd_data(rd_data),
    .regs_flat(regs_flat)
  );

  assign logic_event_route = regs_flat[7:0];
  assign comm_pin_route = regs_flat[15:8];
  assign timer_a_wave_route = regs_flat[23:16];
  assign timer_b_out_route = regs_flat[31:24];

  // Route selects; upper timer A waves move only in split mode
  always_comb begin
    logic_table0_alt = logic_event_route[`PRR_BIT_TABLE0];
    logic_table1_alt = logic_event_route[`PRR_BIT_TABLE1];
    event_pin0_enable = logic_event_route[`PRR_BIT_EVENT0];
    event_pin1_enable = logic_event_route[`PRR_BIT_EVENT1];
    event_pin2_enable = logic_event_route[`PRR_BIT_EVENT2];
    two_wire_alt = comm_pin_route[`PRR_BIT_TWI];
    serial_periph_alt = comm_pin_route[`PRR_BIT_SPI];
    serial_port_alt = comm_pin_route[`PRR_BIT_UART];
    timer_a_wave0_alt = timer_a_wave_route[0];
    timer_a_wave1_alt = timer_a_wave_route[1];
    timer_a_wave2_alt = timer_a_wave_route[2];
    timer_a_wave3_alt = timer_a_wave_route[3] && tca_split;
    timer_a_wave4_alt = timer_a_wave_route[4] && tca_split;
    timer_a_wave5_alt = timer_a_wave_route[5] && tca_split;
    timer_b_out_alt = timer_b_out_route[`PRR_BIT_TCB];
    sel = {timer_b_out_alt,
           timer_a_wave5_alt, timer_a_wave4_alt, timer_a_wave3_alt,
           timer_a_wave2_alt, timer_a_wave1_alt, timer_a_wave0_alt,
           logic_table1_alt, logic_table0_alt,
           {2{serial_port_alt}}, {4{serial_periph_alt}}, {2{two_wire_alt}}};
    src_out = {tcb_out, tca_wave, lut_out, uart_out, spi_out, twi_out};
    src_oe = {1'b1, 6'h3f, 2'h3, uart_oe, spi_oe, twi_oe};
    ev_en = {event_pin2_enable, event_pin1_enable, event_pin0_enable};
  end

  // Each signal drives at most one of its two pins
  for (genvar i = 0; i < `PRR_NSIG; i++) begin : g_pin
    assign def_out_next[i] = !sel[i] && src_out[i];
    assign def_oe_next[i] = !sel[i] && src_oe[i];
    assign alt_out_next[i] = sel[i] && src_out[i];
    assign alt_oe_next[i] = sel[i] && src_oe[i];
  end

  // Inputs come back from whichever pin the signal is routed to
  for (genvar i = 0; i < `PRR_NCOMM; i++) begin : g_in
    assign comm_in_next[i] = sel[i] ? alt_sync2_reg[i] : def_sync2_reg[i];
  end

  for (genvar i = 0; i < `PRR_NEVENT; i++) begin : g_ev
    assign ev_out_next[i] = ev_en[i] && event_ch[i];
    assign ev_oe_next[i] = ev_en[i];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      def_out_reg <= '0;
      def_oe_reg <= '0;
      alt_out_reg <= '0;
      alt_oe_reg <= '0;
      def_sync1_reg <= '0;
      def_sync2_reg <= '0;
      alt_sync1_reg <= '0;
      alt_sync2_reg <= '0;
      comm_in_reg <= '0;
      ev_out_reg <= '0;
      ev_oe_reg <= '0;
    end else begin
      def_out_reg <= def_out_next;
      def_oe_reg <= def_oe_next;
      alt_out_reg <= alt_out_next;
      alt_oe_reg <= alt_oe_next;
      def_sync1_reg <= def_pin_in;
      def_sync2_reg <= def_sync1_reg;
      alt_sync1_reg <= alt_pin_in;
      alt_sync2_reg <= alt_sync1_reg;
      comm_in_reg <= comm_in_next;
      ev_out_reg <= ev_out_next;
      ev_oe_reg <= ev_oe_next;
    end
  end

  assign prdata = {24'h000000, rd_data};
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign def_pin_out = def_out_reg;
  assign def_pin_oe = def_oe_reg;
  assign alt_pin_out = alt_out_reg;
  assign alt_pin_oe = alt_oe_reg;
  assign twi_in = comm_in_reg[`PRR_POS_TWI +: 2];
  assign spi_in = comm_in_reg[`PRR_POS_SPI +: 4];
  assign uart_in = comm_in_reg[`PRR_POS_UART +: 2];
  assign event_pin_out = ev_out_reg;
  assign event_pin_oe = ev_oe_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_pin_exclusive: assert property ((def_pin_oe & alt_pin_oe) == '0)
    else $error("both pins of a signal enabled");
  chk_table1_alt: assert property (1'b1 |=>
    alt_pin_oe[9] == $past(logic_event_route[5]) &&
    alt_pin_out[9] == ($past(logic_event_route[5]) && $past(lut_out[1])))
    else $error("lookup table 1 routing wrong");
  chk_table0_alt: assert property (logic_event_route[4] |=>
    !def_pin_oe[8] && alt_pin_out[8] == $past(lut_out[0]))
    else $error("lookup table 0 routing wrong");
  chk_event2_gate: assert property (1'b1 |=>
    event_pin_oe[2] == $past(logic_event_route[2]) &&
    event_pin_out[2] == ($past(logic_event_route[2]) && $past(event_ch[2])))
    else $error("event output 2 gate wrong");
  chk_event1_gate: assert property (logic_event_route[1] |=>
    event_pin_oe[1] && event_pin_out[1] == $past(event_ch[1]))
    else $error("event output 1 gate wrong");
  chk_event0_gate: assert property (!logic_event_route[0] |=>
    !event_pin_oe[0] && !event_pin_out[0])
    else $error("event output 0 not disconnected");
  chk_twi_alt: assert property (comm_pin_route[4] && $past(comm_pin_route[4]) |=>
    alt_pin_oe[1:0] == $past(twi_oe) && twi_in == $past(alt_pin_in[1:0], 3))
    else $error("two-wire routing wrong");
  chk_spi_alt: assert property (1'b1 |=>
    alt_pin_oe[5:2] == ($past(spi_oe) & {4{$past(comm_pin_route[2])}}))
    else $error("serial peripheral routing wrong");
  chk_uart_in: assert property (comm_pin_route[0] |=>
    uart_in == $past(alt_sync2_reg[7:6]))
    else $error("serial port input routing wrong");
  chk_wave5_split: assert property (1'b1 |=>
    alt_pin_oe[15] == $past(timer_a_wave_route[5] && tca_split))
    else $error("timer A wave 5 routing wrong");
  chk_wave4_split: assert property (!tca_split |=> def_pin_oe[14])
    else $error("timer A wave 4 moved in normal mode");
  chk_wave3_split: assert property (timer_a_wave_route[3] && tca_split |=>
    alt_pin_out[13] == $past(tca_wave[3]) && !def_pin_oe[13])
    else $error("timer A wave 3 routing wrong");
  chk_wave2_alt: assert property (1'b1 |=>
    alt_pin_oe[12] == $past(timer_a_wave_route[2]))
    else $error("timer A wave 2 routing wrong");
  chk_wave1_alt: assert property (1'b1 |=>
    alt_pin_oe[11] == $past(timer_a_wave_route[1]))
    else $error("timer A wave 1 routing wrong");
  chk_wave0_alt: assert property (timer_a_wave_route[0] |=>
    alt_pin_out[10] == $past(tca_wave[0]))
    else $error("timer A wave 0 routing wrong");
  chk_tcb_alt: assert property (1'b1 |=>
    alt_pin_oe[16] == $past(timer_b_out_route[0]) && def_pin_oe[16] != alt_pin_oe[16])
    else $error("timer B routing wrong");
  chk_zero_default: assert property (regs_flat == '0 |=>
    alt_pin_oe == '0 && event_pin_oe == '0 && def_pin_oe[16:8] == 9'h1ff)
    else $error("zero routing not on default pins");
  chk_reserved_zero: assert property (
    (logic_event_route & ~`PRR_MASK_LOGIC_EVENT) == '0 &&
    (comm_pin_route & ~`PRR_MASK_COMM) == '0 &&
    (timer_a_wave_route & ~`PRR_MASK_TIMER_A) == '0 &&
    (timer_b_out_route & ~`PRR_MASK_TIMER_B) == '0)
    else $error("unassigned register bit set");
  chk_ready_pulse: assert property (pready |=> !pready ##0 $past(psel && penable))
    else $error("ready not a single access cycle");

  // Bus answer, write gating, default routing and split-mode routing
  chk_ready_latency: assert property (psel && !penable |=> pready)
    else $error("ready not one cycle after setup");
  chk_unmapped_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access without error");
  chk_strobe_ignore: assert property (
    psel && penable && pready && pwrite && !pstrb[0] |=> $stable(regs_flat))
    else $error("write without byte strobe changed a register");
  chk_table0_default: assert property (!logic_event_route[4] |=>
    def_pin_oe[8] && !alt_pin_oe[8] && def_pin_out[8] == $past(lut_out[0]))
    else $error("lookup table 0 not on default pin");
  chk_twi_default: assert property (!comm_pin_route[4] |=>
    alt_pin_oe[1:0] == 2'h0 && def_pin_oe[1:0] == $past(twi_oe))
    else $error("two-wire signals not on default pins");
  chk_wave2_split: assert property (timer_a_wave_route[2] && tca_split |=>
    alt_pin_oe[12] && !def_pin_oe[12] && alt_pin_out[12] == $past(tca_wave[2]))
    else $error("timer A wave 2 not moved in split mode");
  chk_tcb_default: assert property (!timer_b_out_route[0] |=>
    def_pin_out[16] == $past(tcb_out) && !alt_pin_out[16])
    else $error("timer B output not on default pin");

  cov_lut_alt: cover property (logic_event_route[5] ##1 alt_pin_oe[9]);
  cov_split_alt: cover property (tca_split && timer_a_wave_route[5] ##1 alt_pin_oe[15]);
  cov_write: cover property (wr_en);
  cov_unmapped: cover property (pready && pslverr);
  cov_strobe_off: cover property (psel && penable && pready && pwrite && !pstrb[0]);
endmodule

//--- sim/prr_pad_model.sv
// Pad model for the pin router: each of the 16 communication pads, 8 default and 8 alternative, shows the router's drive when enabled,
// else the level of the outside world. Assumes outside levels come from the bench.
`timescale 1ns/1ps
`include "prr_regs.svh"
module prr_pad_model (
  input wire logic [`PRR_NSIG-1:0] def_pin_out, // Default pad values
  input wire logic [`PRR_NSIG-1:0] def_pin_oe,  // Default pad enables
  input wire logic [`PRR_NSIG-1:0] alt_pin_out, // Alternative pad values
  input wire logic [`PRR_NSIG-1:0] alt_pin_oe,  // Alternative pad enables
  input wire logic [`PRR_NCOMM-1:0] ext_def,    // Outside level, default pads
  input wire logic [`PRR_NCOMM-1:0] ext_alt,    // Outside level, alternative pads
  output logic [`PRR_NCOMM-1:0] def_pin_in,     // Resolved default pad levels
  output logic [`PRR_NCOMM-1:0] alt_pin_in      // Resolved alternative pad levels
);
  // A driven pad wins over the outside level
  assign def_pin_in = (def_pin_oe[7:0] & def_pin_out[7:0]) | (~def_pin_oe[7:0] & ext_def);
  assign alt_pin_in = (alt_pin_oe[7:0] & alt_pin_out[7:0]) | (~alt_pin_oe[7:0] & ext_alt);
endmodule

//--- sim/tb_top.sv
// Self-checking bench of the pin router: APB register access and pin routing.
// Assumes the design package, header and the pad model are compiled first.
`timescale 1ns/1ps
`include "prr_regs.svh"
module tb_top;
  logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er, tca_split = 0, tcb_out = 0;
  logic [1:0] lut_out = '0, twi_out = '0, twi_oe = '0, twi_in, uart_out = '0, uart_oe = '0;
  logic [1:0] uart_in;
  logic [2:0] event_ch = '0, event_pin_out, event_pin_oe;
  logic [3:0] spi_out = '0, spi_oe = '0, spi_in;
  logic [5:0] tca_wave = '0;
  logic [16:0] def_pin_out, def_pin_oe, alt_pin_out, alt_pin_oe, sel, en, val;
  logic [7:0] def_pin_in, alt_pin_in, ext_def = '0, ext_alt = '0, pd, pa;
  int err_count = 0, comparisons = 0;
  logic [7:0] c_le [5] = '{8'h00, 8'h37, 8'h37, 8'h22, 8'h15};
  logic [7:0] c_cm [5] = '{8'h00, 8'h15, 8'h15, 8'h10, 8'h05};
  logic [7:0] c_ta [5] = '{8'h00, 8'h3f, 8'h3f, 8'h2a, 8'h15};
  logic [7:0] c_tb [5] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
  logic c_sp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [16:0] c_val [5] = '{17'h1aaaa, 17'h15555, 17'h1ffff, 17'h0f0f0, 17'h13c3c};
  logic [7:0] c_coe [5] = '{8'hf0, 8'h0f, 8'h00, 8'h3c, 8'hc3};
  logic [2:0] c_ev [5] = '{3'b101, 3'b111, 3'b010, 3'b110, 3'b011};
  logic [7:0] masks [4] = '{`PRR_MASK_LOGIC_EVENT, `PRR_MASK_COMM, `PRR_MASK_TIMER_A,
                            `PRR_MASK_TIMER_B};

  always #10 clock = ~clock;

  prr_pin_route_unit #(.ADDR_W(12)) i_dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lut_out(lut_out),
    .event_ch(event_ch), .twi_out(twi_out), .twi_oe(twi_oe), .twi_in(twi_in),
    .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(spi_in), .uart_out(uart_out),
    .uart_oe(uart_oe), .uart_in(uart_in), .tca_wave(tca_wave), .tca_split(tca_split),
    .tcb_out(tcb_out), .def_pin_out(def_pin_out), .def_pin_oe(def_pin_oe),
    .def_pin_in(def_pin_in), .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe),
    .alt_pin_in(alt_pin_in), .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe));

  prr_pad_model i_pads (.def_pin_out(def_pin_out), .def_pin_oe(def_pin_oe),
    .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe), .ext_def(ext_def),
    .ext_alt(ext_alt), .def_pin_in(def_pin_in), .alt_pin_in(alt_pin_in));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready_timeout", 1'b0, 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    results();
  end

  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, 12'(r * 4), '0, rd, er);
      check("reset_value", {er, rd}, 33'h0);
    end
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 12'(r * 4), 32'hffffffff, rd, er);
      apb(1'b0, 12'(r * 4), '0, rd, er);
      check("readback_mask", {er, rd}, {25'h0, masks[r]});
    end
    // Misaligned and out-of-range accesses are refused and leave registers alone
    apb(1'b1, 12'h001, 32'h0, rd, er);
    check("unmapped_wr_err", er, 1'b1);
    apb(1'b0, 12'h010, '0, rd, er);
    check("unmapped_rd", {er, rd}, {1'b1, 32'h0});
    apb(1'b0, 12'h000, '0, rd, er);
    check("after_unmapped", rd, 32'h37);
    // A write without the low byte strobe leaves the register alone
    pstrb <= 4'he;
    apb(1'b1, 12'h004, 32'h0, rd, er);
    pstrb <= 4'hf;
    apb(1'b0, 12'h004, '0, rd, er);
    check("strobe_off_wr", {er, rd}, {1'b0, 32'h15});
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, {24'h0, c_le[i]}, rd, er);
      apb(1'b1, 12'h004, {24'h0, c_cm[i]}, rd, er);
      apb(1'b1, 12'h008, {24'h0, c_ta[i]}, rd, er);
      apb(1'b1, 12'h00c, {24'h0, c_tb[i]}, rd, er);
      {tcb_out, tca_wave, lut_out, uart_out, spi_out, twi_out} <= c_val[i];
      {uart_oe, spi_oe, twi_oe} <= c_coe[i];
      event_ch <= c_ev[i];
      tca_split <= c_sp[i];
      ext_def <= 8'h5a ^ 8'(i);
      ext_alt <= 8'ha5 ^ 8'(i * 3);
      repeat (8) @(posedge clock);
      sel = {c_tb[i][0], c_ta[i][5:3] & {3{c_sp[i]}}, c_ta[i][2:0], c_le[i][5], c_le[i][4],
             {2{c_cm[i][0]}}, {4{c_cm[i][2]}}, {2{c_cm[i][4]}}};
      val = c_val[i];
      en = {9'h1ff, c_coe[i]};
      pd = 8'((en & ~sel & val) | (~(en & ~sel) & {9'h0, ext_def}));
      pa = 8'((en & sel & val) | (~(en & sel) & {9'h0, ext_alt}));
      check("def_pin_out", def_pin_out, val & ~sel);
      check("def_pin_oe", def_pin_oe, en & ~sel);
      check("alt_pin_out", alt_pin_out, val & sel);
      check("alt_pin_oe", alt_pin_oe, en & sel);
      check("event_pins", {event_pin_oe, event_pin_out},
            {c_le[i][2:0], c_le[i][2:0] & c_ev[i]});
      check("comm_in", {uart_in, spi_in, twi_in},
            (pa & sel[7:0]) | (pd & ~sel[7:0]));
    end
    results();
  end
endmodule
